// ### dv/ctrl_model.sv
// controller model driving the image handshake
`timescale 1ns/1ps
module ctrl_model (
  // clock
  input wire logic sys_clk,
  // images
  input wire serial_cfg_pkg::image_t in_image,
  output serial_cfg_pkg::image_t out_image
);
  import serial_cfg_pkg::*;
  image_t oi = '0;
  assign out_image = oi;
  task automatic xfer(input image_t w, input int gap, output image_t r,
                      output bit ok);
    int n;
    image_t req;
    req = w;
    req[0][14] = 1'b1;
    @(negedge sys_clk);
    oi = req;
    for (n = 0; n < 40 && in_image[0][14] !== 1'b1; n++) @(negedge sys_clk);
    ok = n < 40;
    r = in_image;
    repeat (gap) @(negedge sys_clk);
    oi[0][14] = 1'b0;
    for (n = 0; n < 40 && in_image[0][14] !== 1'b0; n++) @(negedge sys_clk);
    ok = ok && n < 40;
  endtask
endmodule // ctrl_model

// ### dv/serial_cfg_props.sv
// port assertions for the configuration packet decoder
`timescale 1ns/1ps
module serial_cfg_props #(parameter int CLK_HZ = 40000000) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // controller side
  input wire serial_cfg_pkg::image_t out_image,
  input wire logic backup_lost,
  // device side
  input wire serial_cfg_pkg::image_t in_image,
  input wire serial_cfg_pkg::link_settings_s settings,
  input wire logic bit_tick
);
  import serial_cfg_pkg::*;
  wire take = out_image[0][14] & ~in_image[0][14];
  wire rd = out_image[0][13];
  wire sel_ok = out_image[0][3:0] == 4'h2;
  wire wr_take = take & out_image[0][15] & ~rd & sel_ok;
  wire [6:0] status = in_image[0][10:4];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  answer_next_a: assert property (take |=> in_image[0][14])
    else $error("no data-valid after request");
  valid_drop_a: assert property (
    in_image[0][14] && !out_image[0][14] |=> !in_image[0][14])
    else $error("data-valid held after release");
  run_write_a: assert property (
    take && !out_image[0][15] && !rd && sel_ok |=> status == 7'h18)
    else $error("run mode write not refused");
  bad_sel_a: assert property (
    take && rd && !sel_ok |=> status == 7'h08)
    else $error("bad selector not reported");
  tmo_round_a: assert property (in_image[5] % 16'h0032 == 16'h0000)
    else $error("timeout not a multiple of 50");
  full_rts_a: assert property (
    settings.full_duplex |->
    settings.rts_on_delay == 16'h0 && settings.rts_off_delay == 16'h0)
    else $error("rts delay applied in full duplex");
  carrier_hs_a: assert property (
    settings.carrier_detect |-> settings.hw_handshake)
    else $error("handshaking not forced");
  settings_cause_a: assert property (
    !$stable(settings) |-> $past(wr_take, 2) || !$past(rstn, 3))
    else $error("settings changed without a write");
endmodule // serial_cfg_props
bind serial_port_config_packet serial_cfg_props #(.CLK_HZ(CLK_HZ)) props (
  .sys_clk(sys_clk), .rstn(rstn), .out_image(out_image),
  .backup_lost(backup_lost), .in_image(in_image), .settings(settings),
  .bit_tick(bit_tick));

// ### dv/testbench.sv
// testbench for the configuration packet decoder
`timescale 1ns/1ps
module testbench;
  import serial_cfg_pkg::*;
  localparam int HZ = 192000;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic backup_lost = 1'b1;
  image_t out_image, in_image, rd;
  link_settings_s settings;
  logic bit_tick;
  int fails = 0;
  int checks = 0;
  bit ok;
  always #12.5 sys_clk = ~sys_clk;
  serial_port_config_packet #(.CLK_HZ(HZ)) DUT (.sys_clk(sys_clk),
    .rstn(rstn), .out_image(out_image), .backup_lost(backup_lost),
    .in_image(in_image), .settings(settings), .bit_tick(bit_tick));
  ctrl_model ctl (.sys_clk(sys_clk), .in_image(in_image),
    .out_image(out_image));
  task automatic check(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic send(input image_t w, input logic [6:0] st);
    ctl.xfer(w, 2, rd, ok);
    if (!ok) begin
      fails++;
      conclude();
    end
    check("status", rd[0][10:4], st);
  endtask
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (bit_tick !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      fails++;
      conclude();
    end
  endtask
  // write in config mode, selector 2, default words
  function automatic image_t img(input logic [15:0] w1);
    img = '0;
    img[0] = 16'h8002;
    img[1] = w1;
    img[2] = 16'h0002;
    img[3] = 16'h0002;
    img[4] = 16'h00c8;
    img[5] = 16'h2710;
  endfunction
  task automatic do_reset(input logic lost);
    rstn = 1'b0;
    backup_lost = lost;
    repeat (8) @(negedge sys_clk);
    backup_lost = 1'b0;
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic t_defaults;
    image_t w;
    check("fmt", {settings.rate_code, settings.char8, settings.parity,
      settings.stop2}, {3'h2, 1'b1, 2'h0, 1'b0});
    w = img(16'h0);
    w[0] = 16'h2002;
    send(w, 7'h00);
    check("w1", rd[1], 16'h0812);
    check("w5", rd[5], 16'h2710);
    w[0] = 16'h0002;
    send(w, 7'h18);
    $display("defaults done");
  endtask
  task automatic t_codes;
    int n;
    int rates[8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 19200};
    for (int i = 0; i < 8; i++) begin
      send(img({8'h08, i[1], i[1:0], i[0], 1'b0, i[2:0]}), 7'h00);
      check("fmt", {settings.char8, settings.parity, settings.stop2},
        {i[0], (i[1:0] == 2'h3) ? 2'h0 : i[1:0], i[1]});
      wait_tick(n);
      wait_tick(n);
      check("period", n, HZ / rates[i]);
    end
    $display("codes done");
  endtask
  task automatic t_full;
    image_t w;
    int idx[7] = '{5, 5, 0, 2, 2, 3, 3};
    logic [15:0] val[7] = '{16'h0063, 16'h31cf, 16'ha003, 16'h00ff,
      16'h1a02, 16'h00ff, 16'hff02};
    logic [6:0] st[7] = '{7'h10, 7'h10, 7'h08, 7'h0b, 7'h0c, 7'h0d,
      7'h0e};
    w = img(16'h0800);
    w[2] = 16'h1903;
    w[3] = 16'h0705;
    w[6] = 16'h0064;
    w[7] = 16'h0064;
    send(w, 7'h00);
    check("ctl", {settings.init_delay, settings.enq_retries,
      settings.slave_addr}, 24'h190307);
    check("ack", settings.ack_timeout, 16'h00c8);
    check("rts", {settings.rts_on_delay, settings.rts_off_delay},
      32'h0);
    check("nak", {settings.nak_retries, settings.master_addr},
      16'h0500);
    for (int i = 0; i < 7; i++) begin
      w = img(16'h0800);
      w[idx[i]] = val[i];
      send(w, st[i]);
    end
    check("kept", settings.nak_retries, 8'h05);
    $display("full duplex done");
  endtask
  task automatic t_half;
    image_t w;
    w = img(16'h0200);
    w[3] = 16'h00fe;
    w[5] = 16'h00c7;
    w[6] = 16'hffff;
    w[7] = 16'hffdc;
    send(w, 7'h12);
    w[7] = 16'hffdb;
    send(w, 7'h00);
    check("tmo", settings.resp_timeout, 16'h0096);
    check("rts", {settings.rts_on_delay, settings.rts_off_delay},
      32'hffffffdb);
    check("master", settings.master_addr, 8'hfe);
    check("hs", settings.hw_handshake, 1'b1);
    w[0] = 16'ha002;
    send(w, 7'h00);
    check("rd5", rd[5], 16'h0096);
    $display("half duplex done");
  endtask
  task automatic t_persist;
    image_t w;
    w = img(16'h0);
    w[0] = 16'h2002;
    send(w, 7'h00);
    do_reset(1'b0);
    check("kept", settings.resp_timeout, 16'h0096);
    do_reset(1'b1);
    check("lost", {settings.rate_code, settings.full_duplex},
      4'h5);
    $display("persist done");
  endtask
  initial begin
    do_reset(1'b1);
    t_defaults();
    t_codes();
    t_full();
    t_half();
    t_persist();
    conclude();
  end
endmodule // testbench

// ### logic/rate_divider.sv
// bit-rate enable divider selected by the rate code
`timescale 1ns/1ps
`include "serial_cfg_params.svh"
module rate_divider #(
  parameter int CLK_HZ = `CLK_HZ,
  parameter int CNT_W = `RATE_CNT_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // rate select
  input wire logic [2:0] rate_code,
  // one-cycle enable at the bit rate
  output logic tick
);

  localparam logic [CNT_W-1:0] DIV0 = CNT_W'(CLK_HZ / `RATE_0 - 1);
  localparam logic [CNT_W-1:0] DIV1 = CNT_W'(CLK_HZ / `RATE_1 - 1);
  localparam logic [CNT_W-1:0] DIV2 = CNT_W'(CLK_HZ / `RATE_2 - 1);
  localparam logic [CNT_W-1:0] DIV3 = CNT_W'(CLK_HZ / `RATE_3 - 1);
  localparam logic [CNT_W-1:0] DIV4 = CNT_W'(CLK_HZ / `RATE_4 - 1);
  localparam logic [CNT_W-1:0] DIV5 = CNT_W'(CLK_HZ / `RATE_5 - 1);
  localparam logic [CNT_W-1:0] DIV6 = CNT_W'(CLK_HZ / `RATE_6 - 1);

  logic [CNT_W-1:0] cnt;
  logic [2:0] code_q;
  wire code_changed = code_q != rate_code;
  wire [CNT_W-1:0] reload =
    (rate_code == 3'h0) ? DIV0 :
    (rate_code == 3'h1) ? DIV1 :
    (rate_code == 3'h2) ? DIV2 :
    (rate_code == 3'h3) ? DIV3 :
    (rate_code == 3'h4) ? DIV4 :
    (rate_code == 3'h5) ? DIV5 : DIV6;
  wire at_zero = cnt == '0;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      code_q <= 3'h0;
      tick <= 1'b0;
    end else begin
      code_q <= rate_code;
      tick <= at_zero && !code_changed;
      cnt <= (at_zero || code_changed) ? reload : cnt - 1'b1;
    end
  end

endmodule // rate_divider

// ### logic/serial_cfg_params.svh
// constants for the serial port configuration packet decoder
`ifndef SERIAL_CFG_PARAMS_SVH
`define SERIAL_CFG_PARAMS_SVH

// packet word indices
`define W_CTRL 0
`define W_FMT 1
`define W_INIT_RETRY 2
`define W_STATION 3
`define W_ACK_TMO 4
`define W_RESP_TMO 5
`define W_RTS_ON 6
`define W_RTS_OFF 7

// word 0 fields
`define W0_MODE_BIT 15
`define W0_HS_BIT 14
`define W0_RD_BIT 13
`define W0_STAT_HI 10
`define W0_STAT_LO 4
`define W0_SEL_HI 3
`define W0_SEL_LO 0
`define SEL_SERIAL 4'h2

// word 1 fields
`define W1_RATE_HI 2
`define W1_RATE_LO 0
`define W1_CHAR_BIT 4
`define W1_PAR_HI 6
`define W1_PAR_LO 5
`define W1_STOP_BIT 7
`define W1_HWHS_BIT 8
`define W1_CARRIER_BIT 9
`define W1_FULL_BIT 11
`define W1_EMBED_BIT 15

// limits
`define MAX_BYTE_PARAM 8'hfe
`define MAX_INIT_DELAY 8'h19
`define MIN_RESP_TMO 16'h0064
`define MAX_RESP_TMO 16'h31ce
`define TMO_STEP 16'h0032
`define MAX_RTS_OFF 16'hffdb

// status codes
`define ST_OK 7'h00
`define ST_ENQ_RETRY 7'h0b
`define ST_INIT_DELAY 7'h0c
`define ST_MASTER_NAK 7'h0d
`define ST_SLAVE_ADDR 7'h0e
`define ST_SEL_BAD 7'h08
`define ST_RESP_TMO 7'h10
`define ST_RTS_OFF 7'h12
`define ST_RUN_MODE 7'h18

// first power-up words
`define DEF_W1 16'h0812
`define DEF_W2 16'h0002
`define DEF_W3 16'h0002
`define DEF_W4 16'h00c8
`define DEF_W5 16'h2710
`define DEF_W6 16'h0000
`define DEF_W7 16'h0000

// timing
`define CLK_HZ 40000000
`define RATE_0 300
`define RATE_1 600
`define RATE_2 1200
`define RATE_3 2400
`define RATE_4 4800
`define RATE_5 9600
`define RATE_6 19200
`define RATE_CNT_W 18

`endif

// ### logic/serial_cfg_pkg.sv
// types for the serial port configuration packet decoder
package serial_cfg_pkg;

  typedef logic [15:0] word_t;
  typedef logic [7:0][15:0] image_t;

  typedef enum logic [1:0] {
    par_none = 2'h0,
    par_even = 2'h1,
    par_odd = 2'h2
  } parity_e;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_done = 2'b10
  } hs_state_e;

  typedef struct packed {
    logic [2:0] rate_code;
    logic char8;
    parity_e parity;
    logic stop2;
    logic full_duplex;
    logic hw_handshake;
    logic carrier_detect;
    logic embedded_resp;
    logic [7:0] init_delay;
    logic [7:0] enq_retries;
    logic [7:0] slave_addr;
    logic [7:0] master_addr;
    logic [7:0] nak_retries;
    logic [15:0] ack_timeout;
    logic [15:0] resp_timeout;
    logic [15:0] rts_on_delay;
    logic [15:0] rts_off_delay;
  } link_settings_s;

endpackage

// ### logic/serial_port_config_packet.sv
// serial port configuration packet decoder and settings store
`timescale 1ns/1ps
`include "serial_cfg_params.svh"
module serial_port_config_packet #(
  parameter int CLK_HZ = `CLK_HZ
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // output image from the controller
  input wire serial_cfg_pkg::image_t out_image,
  // battery supervisor, high when backed storage is lost
  input wire logic backup_lost,
  // input image to the controller
  output serial_cfg_pkg::image_t in_image,
  // applied link settings
  output serial_cfg_pkg::link_settings_s settings,
  output logic bit_tick
);
  import serial_cfg_pkg::*;

  localparam image_t DEFAULT_IMAGE = {`DEF_W7, `DEF_W6, `DEF_W5, `DEF_W4,
    `DEF_W3, `DEF_W2, `DEF_W1, 16'h0000};

  // command word decode
  wire word_t cmd = out_image[`W_CTRL];
  wire req_hs = cmd[`W0_HS_BIT];
  wire is_read = cmd[`W0_RD_BIT];
  wire cfg_mode = cmd[`W0_MODE_BIT];
  wire [3:0] sel = cmd[`W0_SEL_HI:`W0_SEL_LO];
  wire sel_ok = sel == `SEL_SERIAL;

  // incoming settings words
  wire word_t n_fmt = out_image[`W_FMT];
  wire word_t n_init = out_image[`W_INIT_RETRY];
  wire word_t n_stn = out_image[`W_STATION];
  wire word_t n_tmo = out_image[`W_RESP_TMO];
  wire word_t n_off = out_image[`W_RTS_OFF];
  wire n_full = n_fmt[`W1_FULL_BIT];

  // range checks of a write
  wire err_enq = n_init[7:0] > `MAX_BYTE_PARAM;
  wire err_init = n_init[15:8] > `MAX_INIT_DELAY;
  wire err_mnak = n_stn[7:0] > `MAX_BYTE_PARAM;
  wire err_slave = n_stn[15:8] > `MAX_BYTE_PARAM;
  wire err_tmo = (n_tmo < `MIN_RESP_TMO) ||
    (n_tmo > `MAX_RESP_TMO);
  wire err_off = !n_full && (n_off > `MAX_RTS_OFF);
  wire [6:0] chk_code =
    err_enq ? `ST_ENQ_RETRY :
    err_init ? `ST_INIT_DELAY :
    err_mnak ? `ST_MASTER_NAK :
    err_slave ? `ST_SLAVE_ADDR :
    err_tmo ? `ST_RESP_TMO :
    err_off ? `ST_RTS_OFF : `ST_OK;

  // timeout rounded down to the step
  wire word_t tmo_rem = n_tmo % `TMO_STEP;
  wire word_t tmo_rounded = n_tmo - tmo_rem;

  // handshake state
  hs_state_e state;
  hs_state_e next_state;
  wire take = (state == st_idle) && req_hs;
  wire release_hs = (state == st_done) && !req_hs;

  // transaction outcome
  wire do_read = take && is_read;
  wire write_req = take && !is_read;
  wire write_run = write_req && !cfg_mode;
  wire write_cfg = write_req && cfg_mode;
  wire apply = write_cfg && sel_ok && (chk_code == `ST_OK);
  wire [6:0] resp_code =
    write_run ? `ST_RUN_MODE :
    !sel_ok ? `ST_SEL_BAD :
    is_read ? `ST_OK : chk_code;

  // working and backed settings
  image_t work;
  image_t next_work;
  image_t store;
  logic store_valid;
  logic load_pending;
  logic mode_q;
  logic lost_meta;
  logic lost_sync;
  wire save = mode_q && !cfg_mode && !load_pending;

  image_t next_in_image;
  link_settings_s next_settings;

  // next state
  always_comb begin
    case (state)
      st_idle: next_state = req_hs ? st_done : st_idle;
      st_done: next_state = req_hs ? st_done : st_idle;
      default: next_state = st_idle;
    endcase
  end

  // response into the input image with its valid bit
  always_comb begin
    next_in_image = in_image;
    if (take) begin
      next_in_image[`W_CTRL] = '0;
      next_in_image[`W_CTRL][`W0_MODE_BIT] = cfg_mode;
      next_in_image[`W_CTRL][`W0_HS_BIT] = 1'b1;
      next_in_image[`W_CTRL][`W0_STAT_HI:`W0_STAT_LO] = resp_code;
      next_in_image[`W_CTRL][`W0_SEL_HI:`W0_SEL_LO] = sel;
      if (do_read && sel_ok) begin
        for (int i = 1; i < 8; i++) begin
          next_in_image[i] = work[i];
        end
      end
    end else if (release_hs) begin
      next_in_image[`W_CTRL][`W0_HS_BIT] = 1'b0;
    end
  end

  // working settings update
  always_comb begin
    next_work = work;
    if (load_pending) begin
      next_work = store_valid ? store : DEFAULT_IMAGE;
    end else if (apply) begin
      for (int i = 1; i < 8; i++) begin
        next_work[i] = out_image[i];
      end
      next_work[`W_RESP_TMO] = tmo_rounded;
    end
    next_work[`W_CTRL] = '0;
  end

  // decoded settings
  wire word_t w_fmt = work[`W_FMT];
  wire word_t w_stn = work[`W_STATION];
  wire w_full = w_fmt[`W1_FULL_BIT];
  wire [1:0] w_par = w_fmt[`W1_PAR_HI:`W1_PAR_LO];
  always_comb begin
    next_settings = '0;
    next_settings.rate_code = w_fmt[`W1_RATE_HI:`W1_RATE_LO];
    next_settings.char8 = w_fmt[`W1_CHAR_BIT];
    next_settings.parity = (w_par == 2'h1) ? par_even :
      (w_par == 2'h2) ? par_odd : par_none;
    next_settings.stop2 = w_fmt[`W1_STOP_BIT];
    next_settings.full_duplex = w_full;
    next_settings.carrier_detect = w_fmt[`W1_CARRIER_BIT];
    next_settings.hw_handshake = w_fmt[`W1_HWHS_BIT] ||
      w_fmt[`W1_CARRIER_BIT];
    next_settings.embedded_resp = w_fmt[`W1_EMBED_BIT];
    next_settings.init_delay = work[`W_INIT_RETRY][15:8];
    next_settings.enq_retries = work[`W_INIT_RETRY][7:0];
    next_settings.slave_addr = w_stn[15:8];
    next_settings.master_addr = w_full ? 8'h00 : w_stn[7:0];
    next_settings.nak_retries = w_full ? w_stn[7:0] : 8'h00;
    next_settings.ack_timeout = work[`W_ACK_TMO];
    next_settings.resp_timeout = work[`W_RESP_TMO];
    next_settings.rts_on_delay = w_full ? 16'h0000 :
      work[`W_RTS_ON];
    next_settings.rts_off_delay = w_full ? 16'h0000 :
      work[`W_RTS_OFF];
  end

  // handshake and image registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= st_idle;
      in_image <= '0;
    end else begin
      state <= next_state;
      in_image <= next_in_image;
    end
  end

  // working settings, restore pending after reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      work <= DEFAULT_IMAGE;
      load_pending <= 1'b1;
      mode_q <= 1'b0;
      settings <= '0;
    end else begin
      work <= next_work;
      load_pending <= 1'b0;
      mode_q <= cfg_mode;
      settings <= next_settings;
    end
  end

  // battery supervisor synchroniser, free of rstn so a loss seen
  // during reset clears the backed store before the restore
  always_ff @(posedge sys_clk) begin
    lost_meta <= backup_lost;
    lost_sync <= lost_meta;
  end

  // backed storage, kept across rstn
  always_ff @(posedge sys_clk) begin
    if (save) begin
      store <= work;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (save) begin
      store_valid <= 1'b1;
    end else if (lost_sync) begin
      store_valid <= 1'b0;
    end
  end

  rate_divider #(
    .CLK_HZ(CLK_HZ),
    .CNT_W(`RATE_CNT_W)
  ) u_rate_divider (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .rate_code(settings.rate_code),
    .tick(bit_tick)
  );

endmodule // serial_port_config_packet
